/* common/fdca_pkg.sv */
// constants and types of the frame dma channel arbiter
package fdca_pkg;

    // ************************************************************
    // sizes and channel map
    // ************************************************************
    localparam int CH_NUM = 10;
    localparam int CH_W = 4;
    localparam int PRIO_W = 4;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam logic [CH_W-1:0] XTR_CH_G0 = 4'h0;
    localparam logic [CH_W-1:0] XTR_CH_G1 = 4'h1;
    localparam logic [CH_W-1:0] INJ_CH_FIRST = 4'h2;
    localparam logic [CH_W-1:0] INJ_CH_LAST = 4'h9;
    localparam logic [5:0] PORT_G0 = 6'h35;
    localparam logic [5:0] PORT_G1 = 6'h36;

    // ************************************************************
    // required group and port setup
    // ************************************************************
    localparam logic [1:0] GRP_MODE_DMA = 2'h2;
    localparam logic [3:0] INJ_GAP_REQ = 4'h0;
    localparam logic [1:0] INJ_FMT_REQ = 2'h1;
    localparam logic NO_PRE_REQ = 1'b1;
    localparam logic AWR_REQ = 1'b0;

    // ************************************************************
    // header field and reset values
    // ************************************************************
    localparam int FCS_REQ_BIT = 0;
    localparam logic [CH_W-1:0] CH_RST = 4'h0;
    localparam logic [CH_NUM-1:0] EVT_RST = 10'h000;
    localparam logic [1:0] OK_RST = 2'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA} fdca_state_e;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic sof;
        logic eof;
    } fdca_beat_s;

    typedef struct packed {
        fdca_beat_s beat;
        logic [CH_W-1:0] ch;
        logic grp;
        logic xtr;
        logic fcs_recalc;
        logic [5:0] port;
    } fdca_word_s;

    typedef struct packed {
        logic [1:0] extraction_group_config;
        logic [1:0] injection_group_config;
        logic [3:0] injection_control;
        logic [1:0] injection_format_select;
        logic no_preamble_enable;
        logic tag_aware_rewrite_enable;
    } fdca_grp_cfg_s;

endpackage : fdca_pkg

/* core/fdca_frame_dma_engine.sv */
// channel arbiter, frame path and its fifo
`timescale 1ns/1ps

module fdca_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fdca_fifo_s;

    fdca_fifo_s q;
    fdca_fifo_s d;
    logic full;
    logic empty;

    // ************************************************************
    // pointers carry one wrap bit so full and empty differ
    // ************************************************************
    assign empty = (q.wp == q.rp);
    assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = q.mem[q.rp[AW-1:0]];

    always_comb begin
        d = q;
        if (in_valid && !full) begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp = q.wp + (AW+1)'(1);
        end
        if (out_ready && !empty) begin
            d.rp = q.rp + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : fdca_fifo

module fdca_frame_dma_engine #(
    parameter int CH_NUM = fdca_pkg::CH_NUM,
    parameter int PRIO_W = fdca_pkg::PRIO_W,
    parameter int FIFO_DEPTH = fdca_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    // per-channel service requests and configuration, per-group setup
    input wire logic [CH_NUM-1:0] ch_req,
    input wire logic [CH_NUM-1:0][PRIO_W-1:0] channel_priority,
    input wire logic [CH_NUM-1:0] inject_group_select,
    input wire logic [CH_NUM-1:0] ch_list_end,
    input wire fdca_pkg::fdca_grp_cfg_s [1:0] grp_cfg,
    // manual mode
    input wire logic manual_mode,
    input wire logic [fdca_pkg::CH_W-1:0] manual_ch,
    // source stream of the granted channel
    input wire logic src_valid,
    output logic src_ready,
    input wire fdca_pkg::fdca_beat_s src_beat,
    input wire logic [fdca_pkg::DATA_W-1:0] xtr_header,
    // sink stream towards port or memory
    output logic snk_valid,
    input wire logic snk_ready,
    output fdca_pkg::fdca_word_s snk_word,
    // grant and status
    output logic grant_valid,
    output logic [fdca_pkg::CH_W-1:0] grant_ch,
    output logic grant_grp,
    output logic grant_xtr,
    output logic [1:0] xtr_cfg_ok,
    output logic [1:0] inj_cfg_ok,
    output logic [CH_NUM-1:0] frm_event,
    output logic [CH_NUM-1:0] llp_event
);
    typedef struct packed {
        fdca_pkg::fdca_state_e st;
        logic [fdca_pkg::CH_W-1:0] ch;
        logic grp;
        logic xtr;
        logic fcs;
        logic [1:0] xtr_ok;
        logic [1:0] inj_ok;
        logic [CH_NUM-1:0] frm_evt;
        logic [CH_NUM-1:0] llp_evt;
    } fdca_state_s;

    localparam fdca_state_s STATE_RST = '{
        st: fdca_pkg::ST_IDLE,
        ch: fdca_pkg::CH_RST,
        grp: 1'b0,
        xtr: 1'b0,
        fcs: 1'b0,
        xtr_ok: fdca_pkg::OK_RST,
        inj_ok: fdca_pkg::OK_RST,
        frm_evt: fdca_pkg::EVT_RST,
        llp_evt: fdca_pkg::EVT_RST
    };

    fdca_state_s q;
    fdca_state_s d;
    logic [CH_NUM-1:0] eligible;
    logic [fdca_pkg::CH_W:0] pick;
    logic win_valid;
    logic [fdca_pkg::CH_W-1:0] win_ch;
    logic fifo_in_valid;
    logic fifo_in_ready;
    fdca_pkg::fdca_word_s fifo_in;
    logic src_take;

    // ************************************************************
    // channel map helpers
    // ************************************************************
    function automatic logic fdca_is_xtr(input logic [fdca_pkg::CH_W-1:0] c);
        fdca_is_xtr = (c == fdca_pkg::XTR_CH_G0) || (c == fdca_pkg::XTR_CH_G1);
    endfunction : fdca_is_xtr

    function automatic logic fdca_grp_of(
        input logic [fdca_pkg::CH_W-1:0] c,
        input logic [CH_NUM-1:0] sel
    );
        if (c == fdca_pkg::XTR_CH_G0) begin
            fdca_grp_of = 1'b0;
        end else if (c == fdca_pkg::XTR_CH_G1) begin
            fdca_grp_of = 1'b1;
        end else begin
            fdca_grp_of = sel[c];
        end
    endfunction : fdca_grp_of

    // strict priority; scanning upward with >= lets the larger number win ties
    function automatic logic [fdca_pkg::CH_W:0] fdca_pick(
        input logic [CH_NUM-1:0] el,
        input logic [CH_NUM-1:0][PRIO_W-1:0] pr
    );
        logic found;
        logic [PRIO_W-1:0] best_p;
        logic [fdca_pkg::CH_W-1:0] best_c;
        found = 1'b0;
        best_p = '0;
        best_c = '0;
        for (int i = 0; i < CH_NUM; i++) begin
            if (el[i] && (!found || pr[i] >= best_p)) begin
                found = 1'b1;
                best_p = pr[i];
                best_c = fdca_pkg::CH_W'(i);
            end
        end
        fdca_pick = {found, best_c};
    endfunction : fdca_pick

    // ************************************************************
    // eligibility and decision
    // ************************************************************
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            if (fdca_is_xtr(fdca_pkg::CH_W'(i))) begin
                eligible[i] = ch_req[i]
                    && q.xtr_ok[fdca_grp_of(fdca_pkg::CH_W'(i),
                    inject_group_select)];
            end else begin
                eligible[i] = ch_req[i] && q.inj_ok[inject_group_select[i]];
            end
        end
    end

    assign pick = fdca_pick(eligible, channel_priority);

    // manual mode takes the master's channel as asked, no ranking
    always_comb begin
        if (manual_mode) begin
            win_valid = (manual_ch < fdca_pkg::CH_W'(CH_NUM))
                && eligible[manual_ch];
            win_ch = manual_ch;
        end else begin
            win_valid = pick[fdca_pkg::CH_W];
            win_ch = pick[fdca_pkg::CH_W-1:0];
        end
    end

    // ************************************************************
    // frame path into the fifo
    // ************************************************************
    assign src_ready = (q.st == fdca_pkg::ST_DATA) && fifo_in_ready;
    assign src_take = src_valid && src_ready;

    always_comb begin
        fifo_in.ch = q.ch;
        fifo_in.grp = q.grp;
        fifo_in.xtr = q.xtr;
        fifo_in.port = q.grp ? fdca_pkg::PORT_G1 : fdca_pkg::PORT_G0;
        fifo_in.fcs_recalc = q.fcs;
        if (q.st == fdca_pkg::ST_HDR) begin
            // header leads the extracted frame and carries its sof
            fifo_in.beat.data = xtr_header;
            fifo_in.beat.sof = 1'b1;
            fifo_in.beat.eof = 1'b0;
            fifo_in_valid = 1'b1;
        end else begin
            fifo_in.beat = src_beat;
            if (q.xtr) begin
                fifo_in.beat.sof = 1'b0;
            end
            if (!q.xtr && src_beat.sof) begin
                // first injected word is the header; its flag rules the frame
                fifo_in.fcs_recalc = src_beat.data[fdca_pkg::FCS_REQ_BIT];
            end
            fifo_in_valid = (q.st == fdca_pkg::ST_DATA) && src_valid;
        end
    end

    // ************************************************************
    // grant state machine
    // ************************************************************
    always_comb begin
        d = q;
        d.frm_evt = '0;
        d.llp_evt = '0;
        for (int g = 0; g < 2; g++) begin
            d.xtr_ok[g] = grp_cfg[g].extraction_group_config
                == fdca_pkg::GRP_MODE_DMA;
            d.inj_ok[g] = (grp_cfg[g].injection_group_config
                == fdca_pkg::GRP_MODE_DMA)
                && (grp_cfg[g].injection_control == fdca_pkg::INJ_GAP_REQ)
                && (grp_cfg[g].injection_format_select
                == fdca_pkg::INJ_FMT_REQ)
                && (grp_cfg[g].no_preamble_enable == fdca_pkg::NO_PRE_REQ)
                && (grp_cfg[g].tag_aware_rewrite_enable
                == fdca_pkg::AWR_REQ);
        end
        case (q.st)
            fdca_pkg::ST_IDLE: begin
                // a request only counts once software has activated it
                if (win_valid) begin
                    d.ch = win_ch;
                    d.xtr = fdca_is_xtr(win_ch);
                    d.grp = fdca_grp_of(win_ch, inject_group_select);
                    d.fcs = 1'b0;
                    d.st = fdca_is_xtr(win_ch) ? fdca_pkg::ST_HDR
                        : fdca_pkg::ST_DATA;
                end
            end
            fdca_pkg::ST_HDR: begin
                if (fifo_in_ready) begin
                    d.st = fdca_pkg::ST_DATA;
                end
            end
            fdca_pkg::ST_DATA: begin
                if (src_take) begin
                    d.fcs = fifo_in.fcs_recalc;
                    // grant held to frame end so a port never splits a frame
                    if (src_beat.eof) begin
                        d.st = fdca_pkg::ST_IDLE;
                        d.frm_evt[q.ch] = 1'b1;
                        d.llp_evt[q.ch] = ch_list_end[q.ch];
                    end
                end
            end
            default: begin
                d = STATE_RST;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // buffering between source and sink
    // ************************************************************
    fdca_fifo #(
        .WIDTH($bits(fdca_pkg::fdca_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(snk_valid),
        .out_ready(snk_ready),
        .out_data(snk_word)
    );

    assign grant_valid = (q.st != fdca_pkg::ST_IDLE);
    assign grant_ch = q.ch;
    assign grant_grp = q.grp;
    assign grant_xtr = q.xtr;
    assign xtr_cfg_ok = q.xtr_ok;
    assign inj_cfg_ok = q.inj_ok;
    assign frm_event = q.frm_evt;
    assign llp_event = q.llp_evt;
endmodule : fdca_frame_dma_engine

/* tb/fdca_check_assertions.sv */
// port assertions for the frame dma channel arbiter
`timescale 1ns/1ps
module fdca_check #(
    parameter int CH_NUM = 10,
    parameter int PRIO_W = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [CH_NUM-1:0] ch_req,
    input wire logic [CH_NUM-1:0][PRIO_W-1:0] channel_priority,
    input wire logic [CH_NUM-1:0] inject_group_select,
    input wire logic manual_mode,
    input wire logic [3:0] manual_ch,
    input wire logic src_valid,
    input wire logic src_ready,
    input wire fdca_pkg::fdca_beat_s src_beat,
    input wire logic snk_valid,
    input wire fdca_pkg::fdca_word_s snk_word,
    input wire logic grant_valid,
    input wire logic [3:0] grant_ch,
    input wire logic grant_grp,
    input wire logic grant_xtr,
    input wire logic [1:0] xtr_cfg_ok,
    input wire logic [1:0] inj_cfg_ok,
    input wire logic [CH_NUM-1:0] frm_event
);
    // ****************
    // decision inputs seen at the deciding edge
    // ****************
    logic [CH_NUM-1:0] rq_q, sel_q;
    logic [CH_NUM-1:0][PRIO_W-1:0] pr_q;
    logic [1:0] xok_q, iok_q;
    logic [3:0] mch_q;
    logic man_q, better, eof_acc;
    // eligibility as a net so the assertion sees the sampled copy
    logic [CH_NUM-1:0] okv;
    always_ff @(posedge clk) begin
        rq_q <= ch_req;
        sel_q <= inject_group_select;
        pr_q <= channel_priority;
        xok_q <= xtr_cfg_ok;
        iok_q <= inj_cfg_ok;
        mch_q <= manual_ch;
        man_q <= manual_mode;
    end
    function automatic logic ok(input int c);
        return rq_q[c] && (c < 2 ? xok_q[c] : iok_q[sel_q[c]]);
    endfunction : ok
    always_comb begin
        better = 1'b0;
        for (int c = 0; c < CH_NUM; c++) begin
            okv[c] = ok(c);
            if (ok(c) && (pr_q[c] > pr_q[grant_ch] ||
                (pr_q[c] == pr_q[grant_ch] && c > grant_ch))) begin
                better = 1'b1;
            end
        end
    end
    assign eof_acc = src_valid && src_ready && src_beat.eof && grant_valid;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_strict_prio: assert property (
        $rose(grant_valid) && !man_q |-> okv[grant_ch] && !better)
        else $error("weaker channel granted");
    a_manual_pick: assert property (
        $rose(grant_valid) && man_q |-> grant_ch == mch_q)
        else $error("manual grant mismatch");
    a_frame_hold: assert property (
        grant_valid && !eof_acc |=> grant_valid && $stable(grant_ch))
        else $error("grant moved inside frame");
    a_frame_end: assert property (
        eof_acc |=> !grant_valid)
        else $error("grant kept after end of frame");
    a_xtr_fixed: assert property (
        grant_valid |-> grant_xtr == (grant_ch < 4'h2) &&
        (!grant_xtr || grant_grp == grant_ch[0]))
        else $error("extraction map wrong");
    a_inj_group: assert property (
        $rose(grant_valid) && !grant_xtr |-> grant_grp == sel_q[grant_ch])
        else $error("injection group wrong");
    a_port_map: assert property (
        snk_valid |-> snk_word.port ==
        (snk_word.grp ? fdca_pkg::PORT_G1 : fdca_pkg::PORT_G0))
        else $error("port wrong");
    a_frame_event: assert property (
        eof_acc |=> frm_event[$past(grant_ch)] && $onehot(frm_event))
        else $error("frame event missing");
    a_idle_refuse: assert property (
        !grant_valid |-> !src_ready)
        else $error("source taken while idle");
    a_fcs_header: assert property (
        snk_valid && !snk_word.xtr && snk_word.beat.sof |->
        snk_word.fcs_recalc == snk_word.beat.data[0])
        else $error("fcs request wrong");
endmodule : fdca_check

bind fdca_frame_dma_engine fdca_check #(.CH_NUM(CH_NUM), .PRIO_W(PRIO_W))
    i_fdca_check (.clk, .arst_n, .ch_req, .channel_priority,
    .inject_group_select, .manual_mode, .manual_ch, .src_valid, .src_ready,
    .src_beat, .snk_valid, .snk_word, .grant_valid, .grant_ch, .grant_grp,
    .grant_xtr, .xtr_cfg_ok, .inj_cfg_ok, .frm_event);

/* tb/fdca_mem_model.sv */
// memory side sink model, prompt or slow
`timescale 1ns/1ps
module fdca_mem_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic snk_valid,
    input wire fdca_pkg::fdca_word_s snk_word,
    output logic snk_ready
);
    // ****************
    // acceptance
    // ****************
    fdca_pkg::fdca_word_s rx_q[$];
    logic [2:0] cnt_q;
    // one word in eight when slow, enough to fill the fifo
    assign snk_ready = arst_n && (!slow || cnt_q == 3'h0);
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            if (snk_valid && snk_ready) begin
                rx_q.push_back(snk_word);
            end
        end
    end
endmodule : fdca_mem_model

/* tb/frame_dma_channel_arbiter_test.sv */
// testbench of the frame dma channel arbiter
`timescale 1ns/1ps
module frame_dma_channel_arbiter_test;
    // ****************
    // signals
    // ****************
    localparam fdca_pkg::fdca_grp_cfg_s good = {2'h2, 2'h2, 4'h0, 2'h1,
        1'b1, 1'b0};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic slow = 1'b0;
    logic manual_mode = 1'b0;
    logic src_valid = 1'b0;
    logic [3:0] manual_ch = 4'h0;
    logic [9:0] ch_req = 10'h000;
    logic [9:0] inject_group_select = 10'h000;
    logic [9:0] ch_list_end = 10'h000;
    logic [9:0][3:0] channel_priority = '0;
    logic [31:0] xtr_header = 32'h5a5a_0001;
    fdca_pkg::fdca_beat_s src_beat = '0;
    fdca_pkg::fdca_grp_cfg_s [1:0] grp_cfg = {good, good};
    logic src_ready, snk_valid, snk_ready, grant_valid, grant_grp, grant_xtr;
    logic [3:0] grant_ch;
    logic [1:0] xtr_cfg_ok, inj_cfg_ok;
    logic [9:0] frm_event, llp_event;
    fdca_pkg::fdca_word_s snk_word;
    int fails = 0;
    int n_tests = 0;
    int refused = 0;
    always #2 clk = ~clk;
    fdca_frame_dma_engine i_fdca_frame_dma_engine (.clk, .arst_n, .ch_req,
        .channel_priority, .inject_group_select, .ch_list_end, .grp_cfg,
        .manual_mode, .manual_ch, .src_valid, .src_ready, .src_beat,
        .xtr_header, .snk_valid, .snk_ready, .snk_word, .grant_valid,
        .grant_ch, .grant_grp, .grant_xtr, .xtr_cfg_ok, .inj_cfg_ok,
        .frm_event, .llp_event);
    fdca_mem_model i_fdca_mem_model (.clk, .arst_n, .slow, .snk_valid,
        .snk_word, .snk_ready);
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // one whole frame of the expected channel, then its words
    task automatic xfer(input int ch, input int n, input logic [31:0] hd,
                        input logic [9:0] late);
        int k, w, x;
        logic g;
        fdca_pkg::fdca_word_s wd;
        x = (ch < 2);
        g = x ? ch[0] : inject_group_select[ch];
        k = 0;
        while (grant_valid !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        chk(grant_ch, ch);
        chk(grant_grp, g);
        @(posedge clk);
        ch_req <= ch_req | late;
        for (int i = 0; i < n; i++) begin
            src_valid <= 1'b1;
            src_beat <= {(i == 0 && !x) ? hd : 32'hd000_0000 + i,
                i == 0, i == n - 1};
            @(posedge clk);
            k = 0;
            while (src_ready !== 1'b1 && k < 200) begin
                @(posedge clk);
                k++;
            end
            refused += k;
        end
        src_valid <= 1'b0;
        src_beat <= ~src_beat;
        ch_req[ch] <= 1'b0;
        @(negedge clk);
        chk(frm_event, 10'h1 << ch);
        chk(llp_event, ch_list_end[ch] ? 10'h1 << ch : 10'h0);
        k = 0;
        while (i_fdca_mem_model.rx_q.size() < n + x && k < 500) begin
            @(negedge clk);
            k++;
        end
        chk(i_fdca_mem_model.rx_q.size(), n + x);
        for (int i = 0; i < n + x; i++) begin
            wd = i_fdca_mem_model.rx_q.pop_front();
            w = i - x;
            chk({wd.ch, wd.xtr, wd.beat.sof, wd.beat.eof},
                {ch[3:0], x[0], i == 0, i == n + x - 1});
            chk({wd.grp, wd.port}, {g, (g ? fdca_pkg::PORT_G1 :
                fdca_pkg::PORT_G0)});
            chk(wd.beat.data, i < x ? xtr_header :
                (i == 0 ? hd : 32'hd000_0000 + w));
            if (!x) chk(wd.fcs_recalc, hd[0]);
        end
        chk(snk_valid, 1'b0);
    endtask : xfer
    // ****************
    // scenarios
    // ****************
    task automatic t_setup();
        fdca_pkg::fdca_grp_cfg_s bad;
        chk({xtr_cfg_ok, inj_cfg_ok}, 4'hf);
        @(posedge clk);
        inject_group_select[4] <= 1'b1;
        ch_list_end[1] <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bad = good;
            case (i)
                0: bad.injection_group_config = 2'h1;
                1: bad.injection_control = 4'h1;
                2: bad.injection_format_select = 2'h0;
                3: bad.no_preamble_enable = 1'b0;
                4: bad.tag_aware_rewrite_enable = 1'b1;
                default: bad = {2'h3, 2'h3, 4'h0, 2'h1, 1'b1, 1'b0};
            endcase
            grp_cfg[1] <= bad;
            @(posedge clk);
            // raised an edge late: cfg_ok trails the setup by one cycle
            if (i == 0) ch_req[4] <= 1'b1;
            if (i == 5) ch_req[1] <= 1'b1;
            repeat (3) @(posedge clk);
            chk({xtr_cfg_ok, inj_cfg_ok}, i < 5 ? 4'hd : 4'h5);
            chk(grant_valid, 1'b0);
        end
        grp_cfg[1] <= good;
        xfer(4, 3, 32'h0000_0001, 10'h000);
        xfer(1, 2, 32'h0, 10'h000);
    endtask : t_setup
    task automatic t_prio();
        @(posedge clk);
        channel_priority <= {4'hf, 4'h9, 4'h5, 12'h0, 4'h9, 12'h0};
        inject_group_select <= 10'h080;
        ch_req <= 10'h188;
        xfer(8, 2, 32'h0, 10'h200);
        xfer(9, 1, 32'h1, 10'h000);
        xfer(3, 4, 32'h0, 10'h000);
        xfer(7, 2, 32'h1, 10'h000);
    endtask : t_prio
    task automatic t_manual();
        @(posedge clk);
        manual_mode <= 1'b1;
        manual_ch <= 4'h2;
        channel_priority <= {12'h0, 4'hf, 24'h0};
        ch_req <= 10'h044;
        xfer(2, 2, 32'h0, 10'h000);
        @(posedge clk);
        manual_ch <= 4'ha;
        repeat (6) @(posedge clk);
        chk(grant_valid, 1'b0);
        manual_mode <= 1'b0;
        xfer(6, 1, 32'h0, 10'h000);
    endtask : t_manual
    task automatic t_fifo();
        @(posedge clk);
        slow <= 1'b1;
        ch_req[5] <= 1'b1;
        refused = 0;
        xfer(5, 24, 32'h1, 10'h000);
        chk(refused > 8, 1'b1);
        slow <= 1'b0;
    endtask : t_fifo
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_setup();
        t_prio();
        t_manual();
        t_fifo();
        end_of_test();
    end
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule : frame_dma_channel_arbiter_test
